// ---- src/uart_cfg.svh ----
// Purpose: Timing and field constants of the serial port
// Assumes: Core clock is the block clock
// Notes:   Definitions only
`ifndef UART_CFG_SVH
`define UART_CFG_SVH
`define M0_DIV_LAST   4'hB
`define M0_CLK_HALF   4'h6
`define M2_DIV4_LAST  2'h3
`define S16_LAST      4'hF
`define S16_MID       4'h7
`define T2_TOP        16'hFFFF
`define TX_BITS_M0    4'h8
`define TX_BITS_M1    4'hA
`define TX_BITS_M9    4'hB
`define RX_LAST_M0    4'h7
`define RX_LAST_M1    4'h9
`define RX_LAST_M9    4'hA
`define LINE_IDLE     1'b1
`define LINE_START    1'b0
`endif

// ---- src/uart_pkg.sv ----
// Purpose: Types shared by the serial port
// Assumes: Nothing
// Notes:   Types only
package uart_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_SHIFT} tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_M0} rx_st_t;
  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_filter;
    logic rx_enable;
    logic tx_ninth_bit;
    logic baud_double;
    logic tx_clock_from_timer2;
    logic rx_clock_from_timer2;
  } serial_cfg_t;
endpackage

// ---- src/uart_serial.sv ----
// Purpose: Four-mode serial port with baud generation and TX FIFO
// Assumes: clk_sys_i is the core clock; inputs synchronous
// Notes:   Overview of operation follows
// Overview of operation
// RULE_01 - Both mode bits set select mode three
// RULE_02 - Mode three frames like two, rates like one
// RULE_03 - Buffer write always starts a transmission; a write while the 16-entry FIFO is full is dropped
// RULE_04 - Shift mode receives when enabled, flag clear
// RULE_05 - Async modes receive on start bit if enabled
// RULE_06 - Shift mode bit rate is clock over 12
// RULE_07 - All rates derive from the core clock
// RULE_08 - Mode two rate clock/64, doubled /32
// RULE_09 - Variable rates from timer one or two
// RULE_10 - Timer one rate: overflows times 2^double/32
// RULE_11 - Software keeps timer one interrupt off
// RULE_12 - Reload timing follows timer one overflows
// RULE_13 - Software may reload timer one for slow rates
// RULE_14 - Sixteen timer two overflows per bit
// RULE_15 - Timer two counts every two clocks
// RULE_16 - Direction selects put timer two in baud mode
// RULE_17 - Timer two reloads its 16-bit reload value
// RULE_18 - Frame: start, eight data LSB first, ninth, stop
// RULE_19 - Final shift loads buffer only if flag clear
// RULE_20 - Filter drops frames whose ninth bit is zero
// RULE_21 - TX flag at stop start, RX mid stop
// RULE_22 - Start bit confirmed mid-bit, data sampled centre
// RULE_23 - Transmit starts on next bit tick after write
`include "uart_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Transmit FIFO
module serial_buffer_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_b_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } fifo_st_t;
  fifo_st_t         r;
  fifo_st_t         nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // Handshakes and data
  assign in_ready_o  = (r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (r.cnt != '0);
  assign out_data_o  = mem[r.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer update
  always_comb
  begin
    nxt = r;
    if (push)
    begin
      nxt.wp = r.wp + 1'b1;
    end
    if (pop)
    begin
      nxt.rp = r.rp + 1'b1;
    end
    nxt.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  // State register and storage
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      r <= '0;
    end
    else if (ce_i)
    begin
      r <= nxt;
      if (push)
      begin
        mem[r.wp] <= in_data_i;
      end
    end
  end
endmodule

// ==========================================================
// Serial port core
module uart_serial (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  input  wire uart_pkg::serial_cfg_t cfg_i,
  input  wire logic                  timer1_overflow_i,
  input  wire logic [7:0]            timer2_reload_high_i,
  input  wire logic [7:0]            timer2_reload_low_i,
  input  wire logic                  serial_buffer_write_i,
  input  wire logic [7:0]            serial_buffer_wdata_i,
  output logic                       serial_buffer_ready_o,
  input  wire logic                  receive_flag_clear_i,
  input  wire logic                  transmit_flag_clear_i,
  output logic [7:0]                 serial_buffer_o,
  output logic                       rx_ninth_bit_o,
  output logic                       receive_flag_o,
  output logic                       transmit_flag_o,
  input  wire logic                  rxd_i,
  output logic                       rxd_o,
  output logic                       rxd_oe_o,
  output logic                       txd_o
);
  typedef struct packed {
    logic [3:0]       pre;
    logic             t1div;
    logic             t2ph;
    logic [15:0]      t2cnt;
    uart_pkg::tx_st_t txs;
    logic [10:0]      tsh;
    logic [3:0]       tn;
    logic [3:0]       tph;
    uart_pkg::rx_st_t rxs;
    logic [9:0]       rsh;
    logic [3:0]       rn;
    logic [3:0]       rph;
    logic [7:0]       serial_buffer;
    logic             rb8;
    logic             ri;
    logic             ti;
    logic             txd;
    logic             rxo;
    logic             rxoe;
  } state_t;
  state_t      r;
  state_t      nxt;
  logic        m0;
  logic        m1;
  logic        m2;
  logic        m9;
  logic        m0tick;
  logic        p2tick;
  logic        t1tick;
  logic        t2on;
  logic        t2inc;
  logic        t2ovf;
  logic        s16tx;
  logic        s16rx;
  logic        txbit;
  logic        ri_set;
  logic        ti_set;
  logic        rx_fin;
  logic        rx_ok;
  logic [8:0]  fifo_q;
  logic        fifo_v;
  logic        fifo_pop;
  logic [7:0]  rx_byte;
  logic        rx_bit9;

  // Mode decode
  assign m0 = !cfg_i.mode_select_high && !cfg_i.mode_select_low;
  assign m1 = !cfg_i.mode_select_high && cfg_i.mode_select_low;
  assign m2 = cfg_i.mode_select_high && !cfg_i.mode_select_low;
  assign m9 = cfg_i.mode_select_high; // [RULE_01] [RULE_02]

  // Fixed prescaler ticks from the core clock
  assign m0tick = (r.pre == `M0_DIV_LAST); // [RULE_06] [RULE_07]
  assign p2tick = cfg_i.baud_double ? r.pre[0]
                : (r.pre[1:0] == `M2_DIV4_LAST); // [RULE_08]

  // Timer one overflow gives one x16 tick per one or two overflows
  assign t1tick = timer1_overflow_i
                && (cfg_i.baud_double || r.t1div); // [RULE_10] [RULE_12]

  // Timer two baud generator
  assign t2on  = cfg_i.tx_clock_from_timer2
              || cfg_i.rx_clock_from_timer2; // [RULE_16]
  assign t2inc = t2on && r.t2ph; // [RULE_15]
  assign t2ovf = t2inc && (r.t2cnt == `T2_TOP);

  // Per-direction x16 tick source
  always_comb
  begin
    if (m2)
    begin
      s16tx = p2tick;
      s16rx = p2tick;
    end
    else
    begin
      s16tx = cfg_i.tx_clock_from_timer2 ? t2ovf : t1tick; // [RULE_09] [RULE_14]
      s16rx = cfg_i.rx_clock_from_timer2 ? t2ovf : t1tick; // [RULE_09] [RULE_14]
    end
  end

  // Bit boundary for the transmitter
  assign txbit = m0 ? m0tick : (s16tx && r.tph == `S16_LAST);

  // Received word as it stands once the final sample is shifted in
  always_comb
  begin
    if (m0)
    begin
      rx_byte = {rxd_i, r.rsh[9:3]};
      rx_bit9 = 1'b0;
    end
    else if (m1)
    begin
      rx_byte = r.rsh[9:2];
      rx_bit9 = rxd_i; // Stop bit
    end
    else
    begin
      rx_byte = r.rsh[8:1];
      rx_bit9 = r.rsh[9]; // Ninth data bit
    end
  end

  assign rx_ok = !r.ri && (m0 || !cfg_i.multiproc_filter
               || rx_bit9); // [RULE_19] [RULE_20]
  assign fifo_pop = (r.txs == uart_pkg::TX_IDLE);

  // Next-state logic
  always_comb
  begin
    nxt    = r;
    ti_set = 1'b0;
    rx_fin = 1'b0;
    nxt.pre = m0tick ? 4'h0 : r.pre + 4'h1;
    if (timer1_overflow_i)
    begin
      nxt.t1div = !r.t1div;
    end
    nxt.t2ph = t2on && !r.t2ph;
    // Counter sits at the reload value until baud mode is entered
    if (!t2on)
    begin
      nxt.t2cnt = {timer2_reload_high_i, timer2_reload_low_i};
    end
    else if (t2ovf)
    begin
      nxt.t2cnt = {timer2_reload_high_i, timer2_reload_low_i}; // [RULE_17]
    end
    else if (t2inc)
    begin
      nxt.t2cnt = r.t2cnt + 16'h0001;
    end
    if (s16tx)
    begin
      nxt.tph = r.tph + 4'h1;
    end
    // Transmitter
    unique case (r.txs)
      uart_pkg::TX_IDLE:
      begin
        if (fifo_v) // [RULE_03]
        begin
          nxt.txs = uart_pkg::TX_WAIT;
          if (m0)
          begin
            nxt.tsh = {3'b111, fifo_q[7:0]};
            nxt.tn  = `TX_BITS_M0;
          end
          else
          begin
            nxt.tsh = {`LINE_IDLE, m1 | fifo_q[8], fifo_q[7:0],
                       `LINE_START}; // [RULE_18]
            nxt.tn  = m1 ? `TX_BITS_M1 : `TX_BITS_M9;
          end
        end
      end
      uart_pkg::TX_WAIT:
      begin
        if (txbit) // [RULE_23]
        begin
          nxt.txs = uart_pkg::TX_SHIFT;
        end
      end
      uart_pkg::TX_SHIFT:
      begin
        if (txbit)
        begin
          nxt.tsh = {1'b1, r.tsh[10:1]};
          nxt.tn  = r.tn - 4'h1;
          if (r.tn == 4'h1)
          begin
            nxt.txs = uart_pkg::TX_IDLE;
            ti_set  = m0;
          end
          else if (r.tn == 4'h2 && !m0)
          begin
            ti_set = 1'b1; // [RULE_21]
          end
        end
      end
    endcase
    // Receiver
    if (s16rx)
    begin
      nxt.rph = r.rph + 4'h1;
    end
    unique case (r.rxs)
      uart_pkg::RX_IDLE:
      begin
        nxt.rph = 4'h0;
        if (m0)
        begin
          if (cfg_i.rx_enable && !r.ri && m0tick
              && r.txs == uart_pkg::TX_IDLE && !fifo_v) // [RULE_04]
          begin
            nxt.rxs = uart_pkg::RX_M0;
            nxt.rn  = 4'h0;
          end
        end
        else if (cfg_i.rx_enable && !rxd_i) // [RULE_05]
        begin
          nxt.rxs = uart_pkg::RX_START;
        end
      end
      uart_pkg::RX_START:
      begin
        if (s16rx && r.rph == `S16_MID)
        begin
          nxt.rph = 4'h0;
          nxt.rn  = 4'h0;
          nxt.rxs = rxd_i ? uart_pkg::RX_IDLE
                  : uart_pkg::RX_DATA; // [RULE_22]
        end
      end
      uart_pkg::RX_DATA:
      begin
        if (s16rx && r.rph == `S16_LAST) // [RULE_22]
        begin
          nxt.rsh = {rxd_i, r.rsh[9:1]};
          nxt.rn  = r.rn + 4'h1;
          if (r.rn == (m1 ? `RX_LAST_M1 : `RX_LAST_M9) - 4'h1)
          begin
            rx_fin  = 1'b1;
            nxt.rxs = uart_pkg::RX_IDLE;
          end
        end
      end
      uart_pkg::RX_M0:
      begin
        if (m0tick)
        begin
          nxt.rsh = {rxd_i, r.rsh[9:1]};
          nxt.rn  = r.rn + 4'h1;
          if (r.rn == `RX_LAST_M0)
          begin
            rx_fin  = 1'b1;
            nxt.rxs = uart_pkg::RX_IDLE;
          end
        end
      end
    endcase
    ri_set = 1'b0;
    if (rx_fin && r.rxs == uart_pkg::RX_M0)
    begin
      if (!r.ri)
      begin
        nxt.serial_buffer = rx_byte;
      end
      ri_set = !r.ri;
    end
    else if (rx_fin && rx_ok) // [RULE_19] [RULE_20]
    begin
      nxt.serial_buffer = rx_byte;
      nxt.rb8  = rx_bit9;
      ri_set   = 1'b1;
    end
    // Flags: a hardware set wins over a software clear
    nxt.ri = ri_set || (r.ri && !receive_flag_clear_i); // [RULE_21]
    nxt.ti = ti_set || (r.ti && !transmit_flag_clear_i); // [RULE_21]
    // Pin drive
    nxt.txd  = `LINE_IDLE;
    nxt.rxo  = `LINE_IDLE;
    nxt.rxoe = 1'b0;
    if (m0 && (nxt.txs == uart_pkg::TX_SHIFT || nxt.rxs == uart_pkg::RX_M0))
    begin
      nxt.txd  = (nxt.pre >= `M0_CLK_HALF);
      nxt.rxo  = nxt.tsh[0];
      nxt.rxoe = (nxt.txs == uart_pkg::TX_SHIFT);
    end
    else if (!m0 && nxt.txs == uart_pkg::TX_SHIFT)
    begin
      nxt.txd = nxt.tsh[0]; // [RULE_18]
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_b_i)
    begin
      r     <= '0;
      r.txd <= `LINE_IDLE;
      r.rxo <= `LINE_IDLE;
    end
    else if (ce_i)
    begin
      r <= nxt;
    end
  end

  // Buffer writes pass through the FIFO with the ninth bit
  serial_buffer_fifo #(
    .WIDTH (9),
    .DEPTH (16)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .rst_b_i     (rst_b_i),
    .ce_i        (ce_i),
    .in_valid_i  (serial_buffer_write_i),
    .in_ready_o  (serial_buffer_ready_o),
    .in_data_i   ({cfg_i.tx_ninth_bit, serial_buffer_wdata_i}), // [RULE_23]
    .out_valid_o (fifo_v),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_q)
  );

  // Outputs
  assign serial_buffer_o = r.serial_buffer;
  assign rx_ninth_bit_o  = r.rb8;
  assign receive_flag_o  = r.ri;
  assign transmit_flag_o = r.ti;
  assign rxd_o           = r.rxo;
  assign rxd_oe_o        = r.rxoe;
  assign txd_o           = r.txd;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_b_i || !ce_i);

  sequence s_load;
    r.txs == uart_pkg::TX_IDLE && fifo_v;
  endsequence
  sequence s_go;
    r.txs == uart_pkg::TX_WAIT ##1 r.txs == uart_pkg::TX_SHIFT;
  endsequence

  property p_tx_start;
    s_load |=> r.txs == uart_pkg::TX_WAIT;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx not started"); // [RULE_03]

  property p_start_bit;
    s_go |-> (m0 || txd_o == `LINE_START);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit"); // [RULE_18]

  property p_ti_stop;
    $rose(transmit_flag_o) && !m0 |-> txd_o == `LINE_IDLE;
  endproperty
  a_ti_stop: assert property (p_ti_stop) else $error("ti not at stop"); // [RULE_21]

  property p_ri_hold;
    receive_flag_o && !receive_flag_clear_i |=> receive_flag_o && $stable(serial_buffer_o);
  endproperty
  a_ri_hold: assert property (p_ri_hold) else $error("frame overwrote"); // [RULE_19]

  property p_mp_filter;
    $rose(receive_flag_o) && m9 && cfg_i.multiproc_filter |-> rx_ninth_bit_o;
  endproperty
  a_mp_filter: assert property (p_mp_filter) else $error("filter failed"); // [RULE_20]

  property p_m0_gate;
    r.rxs == uart_pkg::RX_IDLE ##1 r.rxs == uart_pkg::RX_M0
      |-> $past(cfg_i.rx_enable && !receive_flag_o);
  endproperty
  a_m0_gate: assert property (p_m0_gate) else $error("m0 rx ungated"); // [RULE_04]

  property p_rx_ren;
    r.rxs == uart_pkg::RX_IDLE ##1 r.rxs == uart_pkg::RX_START
      |-> $past(cfg_i.rx_enable && !rxd_i);
  endproperty
  a_rx_ren: assert property (p_rx_ren) else $error("rx start ungated"); // [RULE_05]

  property p_t2_reload;
    t2ovf |=> r.t2cnt == $past({timer2_reload_high_i, timer2_reload_low_i});
  endproperty
  a_t2_reload: assert property (p_t2_reload) else $error("t2 reload bad"); // [RULE_17]

  property p_t2_rate;
    t2inc |=> !t2inc;
  endproperty
  a_t2_rate: assert property (p_t2_rate) else $error("t2 too fast"); // [RULE_15]

  property p_m0_div;
    m0tick |=> !m0tick [*8] ##1 !m0tick [*3] ##1 m0tick;
  endproperty
  a_m0_div: assert property (p_m0_div) else $error("m0 rate wrong"); // [RULE_06]

endmodule
`default_nettype wire

// ---- tb/uart_peer.sv ----
// Purpose: Remote serial transceiver facing the serial port
// Assumes: Bit time in core clocks is set by the bench
// Notes:   Async frames LSB first; shift mode uses device clock
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Far-side model
module uart_peer (
  input  wire logic clk_sys_i,
  input  wire logic line_i,
  input  wire logic sdat_i,
  output logic      line_o
);
  int          bit_clks  = 32;
  int          nbits     = 11;
  logic        sync_mode = 1'h0;
  logic [10:0] rx_frame;
  int          rx_cnt    = 0;
  logic [7:0]  m0_rx;
  logic [7:0]  m0_tx     = 8'h00;
  realtime     t_rise    = 0;
  realtime     m0_per    = 0;

  initial line_o = 1'h1;

  // Decode async frames from the device, sampling each bit mid-way
  always
  begin
    @(negedge line_i);
    if (!sync_mode)
    begin
      rx_frame = 11'h000;
      repeat (bit_clks / 2) @(posedge clk_sys_i);
      for (int i = 0; i < nbits; i++)
      begin
        rx_frame[i] = line_i;
        if (i < nbits - 1)
          repeat (bit_clks) @(posedge clk_sys_i);
      end
      rx_cnt++;
    end
  end

  // Shift mode: capture data and shift period on rising shift clock
  always @(posedge line_i)
  begin
    if (sync_mode)
    begin
      m0_per = $realtime - t_rise;
      t_rise = $realtime;
      m0_rx  = {sdat_i, m0_rx[7:1]};
    end
  end

  // Shift mode: present next receive bit on falling shift clock
  always @(negedge line_i)
  begin
    if (sync_mode)
    begin
      line_o = m0_tx[0];
      m0_tx  = {m0_tx[0], m0_tx[7:1]};
    end
  end

  // Drive one async frame, start bit first, line back to idle after
  task automatic send(input logic [10:0] frame, input int n);
    for (int i = 0; i < n; i++)
    begin
      line_o = frame[i];
      repeat (bit_clks) @(negedge clk_sys_i);
    end
    line_o = 1'h1;
  endtask
endmodule
`default_nettype wire

// ---- tb/uart_serial_tb.sv ----
// Purpose: Self-checking bench for the serial port
// Assumes: Timer 1 overflow every two clocks; Timer 2 reload is 16'hFFFE
// Notes:   Table rows first, then hand-written cases
`timescale 1ns/100ps
`default_nettype none

// ==========================================================
// Bench top
module uart_serial_tb;
  typedef struct packed {
    logic [1:0] mode;
    logic       dbl;
    logic       filt;
    logic       ninth;
    logic [7:0] data;
    logic       flag;
  } row_t;

  logic                  clk_sys_i   = 1'h0;
  logic                  rst_b       = 1'h0;
  logic                  ce          = 1'h1;
  logic [7:0]            t2_high     = 8'hFF;
  logic [7:0]            t2_low      = 8'hFE;
  uart_pkg::serial_cfg_t cfg         = 8'h00;
  logic                  t1_ovf      = 1'h0;
  logic                  serial_buffer_write  = 1'h0;
  logic [7:0]            serial_buffer_wdata  = 8'h00;
  logic                  rf_clr      = 1'h0;
  logic                  tf_clr      = 1'h0;
  logic                  serial_buffer_ready_o;
  logic [7:0]            serial_buffer_o;
  logic                  rx_ninth_bit_o;
  logic                  receive_flag_o;
  logic                  transmit_flag_o;
  logic                  rxd_o;
  logic                  rxd_oe_o;
  logic                  txd_o;
  logic                  peer_line;
  logic                  rxd_wire;
  int                    miscompares = 0;
  int                    checked     = 0;
  row_t                  r;
  logic [10:0]           fr;
  int                    nb;
  int                    n0;
  int                    acc;
  row_t                  rows [5] = '{
    '{2'h2, 1'h1, 1'h0, 1'h1, 8'hA5, 1'h1},
    '{2'h2, 1'h0, 1'h0, 1'h0, 8'h3C, 1'h1},
    '{2'h3, 1'h1, 1'h1, 1'h1, 8'h81, 1'h1},
    '{2'h3, 1'h0, 1'h1, 1'h0, 8'h7E, 1'h0},
    '{2'h1, 1'h1, 1'h0, 1'h0, 8'h5A, 1'h1}};

  // Clock, timer overflow pulses and the shared data wire
  always #20 clk_sys_i = ~clk_sys_i;
  // Timer one runs free with its interrupt off, so no reload is modelled
  always @(negedge clk_sys_i) t1_ovf <= ~t1_ovf;
  assign rxd_wire = rxd_oe_o ? rxd_o : peer_line;

  uart_serial dut (
    .clk_sys_i            (clk_sys_i),
    .rst_b_i              (rst_b),
    .ce_i                 (ce),
    .cfg_i                (cfg),
    .timer1_overflow_i    (t1_ovf),
    .timer2_reload_high_i (t2_high),
    .timer2_reload_low_i  (t2_low),
    .serial_buffer_write_i         (serial_buffer_write),
    .serial_buffer_wdata_i         (serial_buffer_wdata),
    .serial_buffer_ready_o         (serial_buffer_ready_o),
    .receive_flag_clear_i (rf_clr),
    .transmit_flag_clear_i(tf_clr),
    .serial_buffer_o      (serial_buffer_o),
    .rx_ninth_bit_o       (rx_ninth_bit_o),
    .receive_flag_o       (receive_flag_o),
    .transmit_flag_o      (transmit_flag_o),
    .rxd_i                (rxd_wire),
    .rxd_o                (rxd_o),
    .rxd_oe_o             (rxd_oe_o),
    .txd_o                (txd_o)
  );

  uart_peer u_peer (
    .clk_sys_i(clk_sys_i),
    .line_i   (txd_o),
    .sdat_i   (rxd_o),
    .line_o   (peer_line)
  );

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [10:0] mk(input logic [7:0] d, input logic n, input int w);
    return (w == 11) ? {1'h1, n, d, 1'h0} : {2'h1, d, 1'h0};
  endfunction

  task automatic write_byte(input logic [7:0] d);
    @(negedge clk_sys_i);
    serial_buffer_wdata = d;
    serial_buffer_write = 1'h1;
    @(negedge clk_sys_i);
    serial_buffer_write = 1'h0;
  endtask

  task automatic clear_flags;
    @(negedge clk_sys_i);
    rf_clr = 1'h1;
    tf_clr = 1'h1;
    @(negedge clk_sys_i);
    rf_clr = 1'h0;
    tf_clr = 1'h0;
  endtask

  task automatic wait_frames(input int n);
    for (int k = 0; k < 20000 && u_peer.rx_cnt < n; k++)
      @(negedge clk_sys_i);
    check(16'(u_peer.rx_cnt >= n), 16'h0001);
  endtask

  task automatic finish_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (60000) @(posedge clk_sys_i);
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    finish_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (20) @(negedge clk_sys_i);
    rst_b = 1'h1;
    @(negedge clk_sys_i);
    check({txd_o, rxd_o, rxd_oe_o, transmit_flag_o, receive_flag_o, serial_buffer_ready_o,
           serial_buffer_o}, {6'h31, 8'h00});
    $display("reset done");
    // Table: transmit then receive in modes 2 and 3 at both rates, mode 1 doubled
    foreach (rows[i])
    begin
      r  = rows[i];
      nb = (r.mode == 2'h1) ? 10 : 11;
      u_peer.bit_clks = r.dbl ? 32 : 64;
      u_peer.nbits = nb;
      cfg = {r.mode, r.filt, 1'h1, r.ninth, r.dbl, 2'h0};
      n0 = u_peer.rx_cnt;
      fr = mk(r.data, r.ninth, nb);
      write_byte(r.data);
      wait_frames(n0 + 1);
      check(u_peer.rx_frame, fr);
      check(transmit_flag_o, 1'h1);
      u_peer.send(fr, nb);
      repeat (2) @(negedge clk_sys_i);
      check(receive_flag_o, r.flag);
      if (r.flag)
        check({rx_ninth_bit_o, serial_buffer_o}, {fr[9], r.data});
      clear_flags();
      $display("row %0d done", i);
    end
    // A full receive flag drops the next frame
    cfg = {2'h3, 1'h0, 1'h1, 1'h0, 1'h1, 2'h0};
    u_peer.bit_clks = 32;
    u_peer.nbits = 11;
    u_peer.send(mk(8'h11, 1'h0, 11), 11);
    u_peer.send(mk(8'h22, 1'h0, 11), 11);
    check({receive_flag_o, serial_buffer_o}, {1'h1, 8'h11});
    clear_flags();
    $display("overrun done");
    // A short low glitch is not taken as a start bit
    u_peer.bit_clks = 4;
    u_peer.send(11'h000, 1);
    u_peer.bit_clks = 32;
    repeat (400) @(negedge clk_sys_i);
    check(receive_flag_o, 1'h0);
    $display("glitch done");
    // Back-to-back writes fill the queue, then it drains in order
    n0 = u_peer.rx_cnt;
    acc = 0;
    for (int i = 0; i < 20; i++)
    begin
      @(negedge clk_sys_i);
      serial_buffer_wdata = 8'(acc);
      serial_buffer_write = 1'h1;
      acc += int'(serial_buffer_ready_o);
    end
    @(negedge clk_sys_i);
    serial_buffer_write = 1'h0;
    check(16'(acc == 16 || acc == 17), 16'h0001);
    wait_frames(n0 + acc);
    check(u_peer.rx_frame, mk(8'(acc - 1), 1'h0, 11));
    check(serial_buffer_ready_o, 1'h1);
    clear_flags();
    $display("queue done");
    // Frozen clock enable ignores a write and holds the outputs
    n0 = u_peer.rx_cnt;
    ce = 1'h0;
    write_byte(8'hE7);
    repeat (50) @(negedge clk_sys_i);
    check({txd_o, transmit_flag_o, serial_buffer_ready_o}, 3'h5);
    ce = 1'h1;
    repeat (800) @(negedge clk_sys_i);
    check(u_peer.rx_cnt, n0);
    $display("freeze done");
    // Transmit on Timer 2 at 64 clocks a bit, receive on Timer 1 at 32
    cfg = {2'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
    u_peer.bit_clks = 64;
    u_peer.nbits = 10;
    n0 = u_peer.rx_cnt;
    write_byte(8'h96);
    wait_frames(n0 + 1);
    check(u_peer.rx_frame, mk(8'h96, 1'h0, 10));
    u_peer.bit_clks = 32;
    u_peer.send(mk(8'h69, 1'h0, 10), 10);
    repeat (2) @(negedge clk_sys_i);
    check({receive_flag_o, serial_buffer_o}, {1'h1, 8'h69});
    clear_flags();
    $display("timer two done");
    // Shift mode: transmit, then receive once enabled with flag clear
    u_peer.sync_mode = 1'h1;
    u_peer.m0_tx = 8'h4B;
    cfg = 8'h00;
    write_byte(8'hC6);
    for (int k = 0; k < 300 && !transmit_flag_o; k++)
      @(negedge clk_sys_i);
    repeat (12) @(negedge clk_sys_i);
    check(u_peer.m0_rx, 8'hC6);
    check(16'(u_peer.m0_per == 480.0), 16'h0001);
    check(receive_flag_o, 1'h0);
    cfg = 8'h10;
    for (int k = 0; k < 300 && !receive_flag_o; k++)
      @(negedge clk_sys_i);
    check({receive_flag_o, serial_buffer_o}, {1'h1, 8'h4B});
    $display("shift mode done");
    finish_test();
  end
endmodule
`default_nettype wire
